/* File: bench/nand_flash_model.sv */
// Behavioural flash device on the far side of the host pins.
// Assumes the bench resolves the shared bus; busy times are shortened.
`timescale 1ns/1ns
`include "nand_host_params.svh"
module nand_flash_model #(
  parameter int BUSY_NS = 2000
) (
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_rd_strobe_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_bus,
  output logic [7:0] o_bus,
  output logic o_rb
);
  logic [7:0] arr [int];
  logic [7:0] pbuf [0:2111];
  logic [7:0] q = 8'h00;
  logic [15:0] row = 16'h0000;
  logic [11:0] col = 12'h000;
  logic busy = 1'b0;
  logic stat_mode = 1'b0;
  int acnt = 0;
  // ****************
  // Pins and array
  // ****************
  // Pull-up on ready; status shown whether selected or not
  assign o_rb = !busy;
  // Released bus shows the inverse, never a stale copy
  assign o_bus = (!i_ce_n && !i_rd_strobe_n) ? q : ~q;
  // Busy runs out on its own, chip select is not looked at
  task automatic run_busy();
    busy = 1'b1;
    fork
      #BUSY_NS busy = 1'b0;
    join_none
  endtask
  // Latch on the write-strobe rise
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle && (!busy || i_bus == `CMD_RESET || i_bus == `CMD_STATUS)) begin
      stat_mode = (i_bus == `CMD_STATUS);
      case (i_bus)
        `CMD_READ1: acnt = 0;
        `CMD_PROG1: begin
          acnt = 0;
          foreach (pbuf[c]) pbuf[c] = 8'hff;
        end
        `CMD_ERASE1: acnt = 2; // Row bytes only
        `CMD_READ2: begin
          for (int c = 0; c < 2112; c++) pbuf[c] = arr.exists(int'({row, c[11:0]})) ?
            arr[int'({row, c[11:0]})] : 8'hff;
          run_busy();
        end
        `CMD_PROG2: begin
          for (int c = 0; c < 2112; c++) if (i_wp_n && pbuf[c] !== 8'hff)
            arr[int'({row, c[11:0]})] = pbuf[c];
          run_busy();
        end
        `CMD_ERASE2: begin
          for (int p = 0; p < 64; p++) for (int c = 0; c < 2112; c++) if (i_wp_n)
            arr.delete(int'({row[15:6], p[5:0], c[11:0]}));
          run_busy();
        end
        default: ;
      endcase
    end else if (!i_ce_n && i_ale && !busy) begin
      case (acnt)
        0: col[7:0] = i_bus;
        1: col[11:8] = i_bus[3:0];
        2: row[7:0] = i_bus;
        3: row[15:8] = i_bus;
        default: ; // Extra bytes ignored
      endcase
      acnt++;
    end else if (!i_ce_n && !i_cle && !busy) begin
      if (col < `PAGE_BYTES) pbuf[col] = i_bus;
      col++;
    end
  end
  // Read strobe fall presents the byte and, outside status mode, moves the column on
  always @(negedge i_rd_strobe_n) begin
    if (!i_ce_n) begin
      q = stat_mode ? {i_wp_n, !busy, 6'h00} : (col < `PAGE_BYTES ? pbuf[col] : 8'hff);
      if (!stat_mode) col++;
    end
  end
endmodule

/* File: bench/nand_host_monitor.sv */
// Checker for the NAND host flash pins and its user handshake.
// Assumes it is bound into nand_host and sees only that module's ports.
`timescale 1ns/1ns
module nand_host_monitor (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_rd_strobe_n,
  input wire logic o_wp_n,
  input wire logic [7:0] o_mux_bus_lines,
  input wire logic o_mux_bus_oe,
  input wire logic i_rb
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // ****************
  // Strobe phases
  // ****************
  // Byte, latch selects held while write strobe low, byte alone still held at rise
  sequence wr_low_s;
    (!o_we_n && $stable(o_mux_bus_lines) && $stable(o_cle) && $stable(o_ale))[*2]
      ##1 (o_we_n && $stable(o_mux_bus_lines));
  endsequence
  // Three low then three high keeps the cycle well above the minimum
  sequence rd_cycle_s;
    (!o_rd_strobe_n)[*2] ##1 o_rd_strobe_n[*3];
  endsequence
  cmd_addr_excl_a: assert property (!(o_cle && o_ale)) else $error("cle and ale both high");
  write_cycle_a: assert property ($fell(o_we_n) |=> wr_low_s) else $error("write cycle bad");
  read_cycle_a: assert property ($fell(o_rd_strobe_n) |=> rd_cycle_s) else $error("read cycle bad");
  strobe_excl_a: assert property (!(!o_we_n && !o_rd_strobe_n)) else $error("both strobes low");
  read_float_a: assert property (!o_rd_strobe_n |-> o_mux_bus_oe) else $error("host drives on read");
  select_held_a: assert property ((!o_we_n || !o_rd_strobe_n) |-> !o_ce_n) else $error("chip not selected");
  read_ready_a: assert property ($fell(o_rd_strobe_n) |-> i_rb) else $error("read while busy");
  protect_off_a: assert property (!o_we_n |-> o_wp_n) else $error("write while protected");
  start_taken_a: assert property (i_start && !o_busy |=> o_busy) else $error("start not taken");
  done_pulse_a: assert property (o_done |=> !o_done) else $error("done longer than one cycle");
endmodule

bind nand_host nand_host_monitor nand_host_monitor_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
  .i_start(i_start), .o_busy(o_busy), .o_done(o_done), .o_ce_n(o_ce_n), .o_cle(o_cle),
  .o_ale(o_ale), .o_we_n(o_we_n), .o_rd_strobe_n(o_rd_strobe_n), .o_wp_n(o_wp_n),
  .o_mux_bus_lines(o_mux_bus_lines), .o_mux_bus_oe(o_mux_bus_oe), .i_rb(i_rb));

/* File: bench/nand_host_tb.sv */
// Self-checking bench: nand_host against a behavioural flash model.
// Assumes the design files and the shared package compile first.
`timescale 1ns/1ns
module nand_host_tb;
  import nand_host_pkg::*;
  logic i_mclk, i_sys_rst = 1'b1, i_start = 1'b0, i_wr_valid = 1'b0, i_rd_ready = 1'b0;
  logic [1:0] i_op = 2'h0;
  logic [15:0] i_row = 16'h0000;
  logic [11:0] i_col = 12'h000, i_len = 12'h001;
  logic [7:0] i_wr_data = 8'h00;
  logic o_busy, o_done, o_error, o_wr_ready, o_rd_valid, ce_n, cle, ale, we_n, re_n, wp_n;
  logic oe_n, rb;
  logic [7:0] o_status, o_rd_data, host_bus, dev_bus;
  wire [7:0] bus_w = oe_n ? dev_bus : host_bus;
  int n_errors = 0, tests_run = 0;
  logic [7:0] got [$];
  nand_host #(.TIMEOUT_CYC(2000)) nand_host_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_start(i_start), .i_op(i_op), .i_row(i_row), .i_col(i_col), .i_len(i_len),
    .o_busy(o_busy), .o_done(o_done), .o_error(o_error), .o_status(o_status),
    .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready), .o_ce_n(ce_n),
    .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_rd_strobe_n(re_n), .o_wp_n(wp_n),
    .o_mux_bus_lines(host_bus), .o_mux_bus_oe(oe_n), .i_mux_bus_lines(bus_w), .i_rb(rb));
  nand_flash_model nand_flash_model_i (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
    .i_rd_strobe_n(re_n), .i_wp_n(wp_n), .i_bus(bus_w), .o_bus(dev_bus), .o_rb(rb));
  // ****************
  // Shared tasks
  // ****************
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  function automatic logic [7:0] pat(input int k);
    return 8'h3c ^ 8'(k * 7);
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One operation; poke tries a second start while busy
  task automatic run(input logic [1:0] op, input logic [15:0] row, input logic [11:0] col,
                     input logic [11:0] len, input logic poke);
    int k, n;
    logic took;
    k = 0;
    took = 1'b0;
    got.delete();
    i_op = op;
    i_row = row;
    i_col = col;
    i_len = len;
    i_wr_data = pat(0);
    i_wr_valid = 1'b1;
    i_start = 1'b1;
    @(posedge i_mclk);
    #1;
    for (n = 0; n < 20000 && o_done !== 1'b1; n++) begin
      @(posedge i_mclk);
      #1;
      if (took) k++;
      if (took) i_wr_data = pat(k);
      took = o_wr_ready;
      i_start = poke && n == 20;
      i_rd_ready = n[0] | n[1]; // Stall one cycle in four
      if (o_rd_valid === 1'b1 && i_rd_ready) got.push_back(o_rd_data);
    end
    i_wr_valid = 1'b0;
    if (n == 20000) begin
      n_errors++;
      print_verdict();
    end
    // Drain what the buffer still holds
    for (n = 0; n < 8; n++) begin
      @(posedge i_mclk);
      #1;
      i_rd_ready = 1'b1;
      if (o_rd_valid === 1'b1) got.push_back(o_rd_data);
    end
    chk8(o_status, 8'hc0);
    chk8({7'h00, o_error}, 8'h00);
  endtask
  // Six bytes around the spare boundary; four were programmed
  task automatic readback(input logic erased);
    run(op_read, 16'h0041, 12'd2045, 12'd6, 1'b0);
    chk8(8'(got.size()), 8'h06);
    for (int i = 0; i < 6; i++)
      chk8(got[i], (erased || i == 0 || i == 5) ? 8'hff : pat(i - 1));
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (4) @(posedge i_mclk);
    #1;
    i_sys_rst = 1'b0;
    run(op_reset, 16'h0000, 12'h000, 12'h001, 1'b0);
    $display("test reset done");
    run(op_program, 16'h0041, 12'd2046, 12'd4, 1'b1);
    $display("test program done");
    readback(1'b0);
    $display("test read done");
    run(op_erase, 16'h0043, 12'h000, 12'h001, 1'b0);
    readback(1'b1);
    $display("test erase done");
    print_verdict();
  end
endmodule

/* File: hw/nand_host.sv */
// Host-side NAND flash controller: drives command, address and data pins.
// Assumes one flash device on the pins and a user that issues one op at a time.
`timescale 1ns/1ns
`include "nand_host_params.svh"
module nand_host
  import nand_host_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `TIMEOUT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // User command port
  input wire logic i_start,
  input wire logic [1:0] i_op,
  input wire logic [15:0] i_row,
  input wire logic [11:0] i_col,
  input wire logic [11:0] i_len,
  output logic o_busy,
  output logic o_done,
  output logic o_error,
  output logic [7:0] o_status,
  // Program data in
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_ready,
  // Read data out
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  input wire logic i_rd_ready,
  // Flash pins
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_rd_strobe_n,
  output logic o_wp_n,
  output logic [7:0] o_mux_bus_lines,
  output logic o_mux_bus_oe,
  input wire logic [7:0] i_mux_bus_lines,
  input wire logic i_rb
);
  localparam int unsigned STROBE_CYC = `STROBE_CYC;
  localparam int unsigned WB_CYC = `WB_CYC;

  typedef struct packed {
    state_t st;
    op_t op;
    logic [15:0] row;
    logic [11:0] col;
    logic [11:0] len;
    logic [11:0] cnt;
    logic [2:0] abyte;
    logic [1:0] phase;
    logic [3:0] tick;
    logic [23:0] wait_cnt;
    logic [7:0] rdata;
    logic rd_vld;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic [7:0] dout;
    logic oe_n;
    logic busy;
    logic done;
    logic error;
    logic [7:0] status;
    logic wr_ready;
    logic [1:0] rb_sync;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  byte_stream_if rd_up();
  byte_stream_if rd_down();
  logic rb_ready;
  logic phase_end;
  logic [7:0] addr_byte;

  // Read bytes pass a skid buffer so a stalled user loses nothing
  skid_buffer skid_buffer_i (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .up(rd_up.dst),
    .down(rd_down.src)
  );
  assign rd_up.valid = s.rd_vld;
  assign rd_up.data = s.rdata;
  assign rd_down.ready = i_rd_ready;

  // Ready/busy is read only after its second sync stage
  assign rb_ready = s.rb_sync[1]; // R09
  assign phase_end = (s.tick == 4'(STROBE_CYC - 1));

  // Column first, then row, low byte first
  always_comb begin
    case (s.abyte)
      3'h0: addr_byte = s.col[7:0]; // R19
      3'h1: addr_byte = {4'h0, s.col[11:8]}; // R22
      3'h2: addr_byte = s.row[7:0];
      default: addr_byte = s.row[15:8];
    endcase
  end

  // Main sequencer: each bus cycle is strobe low phase then high phase
  always_comb begin
    next_s = s;
    next_s.rb_sync = {s.rb_sync[0], i_rb};
    next_s.din_s1 = i_mux_bus_lines;
    next_s.din_s2 = s.din_s1;
    next_s.done = 1'b0;
    next_s.rd_vld = 1'b0;
    next_s.wr_ready = 1'b0;
    next_s.tick = phase_end ? 4'h0 : s.tick + 4'h1;
    if (phase_end) begin
      next_s.phase = s.phase + 2'h1;
    end
    case (s.st)
      st_idle: begin
        next_s.tick = 4'h0;
        next_s.phase = 2'h0;
        next_s.ce_n = 1'b1;
        next_s.oe_n = 1'b1;
        if (i_start) begin
          next_s.op = op_t'(i_op);
          next_s.row = i_row;
          next_s.col = i_col;
          next_s.len = i_len;
          next_s.cnt = 12'h0;
          next_s.abyte = 3'h0;
          next_s.busy = 1'b1;
          next_s.error = 1'b0;
          next_s.ce_n = 1'b0; // R24
          next_s.st = st_cmd1;
        end
      end
      st_cmd1: begin
        next_s.cle = 1'b1; // R01
        next_s.oe_n = 1'b0;
        case (s.op)
          op_read: next_s.dout = `CMD_READ1; // R20
          op_program: next_s.dout = `CMD_PROG1; // R20
          op_erase: next_s.dout = `CMD_ERASE1; // R20
          default: next_s.dout = `CMD_RESET;
        endcase
        next_s.we_n = (s.phase == 2'h0) ? 1'b0 : 1'b1;
        if (phase_end && s.phase == 2'h1) begin
          next_s.cle = 1'b0;
          next_s.phase = 2'h0;
          if (s.op == op_reset) begin
            next_s.oe_n = 1'b1;
            next_s.wait_cnt = 24'h0;
            next_s.st = st_wait_busy;
          end else begin
            next_s.abyte = (s.op == op_erase) ? 3'h2 : 3'h0; // R12
            next_s.st = st_addr;
          end
        end
      end
      st_addr: begin
        next_s.ale = 1'b1; // R02
        next_s.dout = addr_byte;
        next_s.we_n = (s.phase == 2'h0) ? 1'b0 : 1'b1;
        if (phase_end && s.phase == 2'h1) begin
          next_s.phase = 2'h0;
          next_s.abyte = s.abyte + 3'h1;
          if (s.abyte == `ADDR_BYTES - 3'h1) begin
            next_s.ale = 1'b0; // R02
            next_s.st = (s.op == op_program) ? st_wdata : st_cmd2;
          end
        end
      end
      st_wdata: begin
        // Hold the strobe high until a byte is offered
        if (s.phase == 2'h0 && s.tick == 4'h0 && !s.we_n) begin
          next_s.we_n = 1'b0;
        end
        if (s.phase == 2'h0 && s.tick == 4'h0 && s.we_n) begin
          if (i_wr_valid) begin
            next_s.dout = i_wr_data; // R03
            next_s.wr_ready = 1'b1;
            next_s.we_n = 1'b0;
          end else begin
            next_s.tick = 4'h0;
            next_s.phase = 2'h0;
          end
        end
        // Rise one clock into the high phase: three low, three high
        if (s.phase == 2'h1 && s.tick == 4'h0) begin
          next_s.we_n = 1'b1;
        end
        if (phase_end && s.phase == 2'h1) begin
          next_s.phase = 2'h0;
          next_s.cnt = s.cnt + 12'h1;
          if (s.cnt + 12'h1 == s.len || s.col + s.cnt + 12'h1 == `PAGE_BYTES) begin // R10
            next_s.st = st_cmd2;
          end
        end
      end
      st_cmd2: begin
        next_s.cle = 1'b1; // R01
        next_s.oe_n = 1'b0;
        case (s.op)
          op_read: next_s.dout = `CMD_READ2; // R20
          op_program: next_s.dout = `CMD_PROG2; // R20
          default: next_s.dout = `CMD_ERASE2; // R20
        endcase
        next_s.we_n = (s.phase == 2'h0) ? 1'b0 : 1'b1;
        if (phase_end && s.phase == 2'h1) begin
          next_s.cle = 1'b0;
          next_s.oe_n = 1'b1; // R05
          next_s.wait_cnt = 24'h0;
          next_s.st = st_wait_busy;
        end
      end
      st_wait_busy: begin
        // Ready/busy falls some time after the execute command
        next_s.wait_cnt = s.wait_cnt + 24'h1;
        if (s.wait_cnt == 24'(WB_CYC + 2)) begin
          next_s.wait_cnt = 24'h0;
          next_s.st = st_wait_ready;
        end
      end
      st_wait_ready: begin
        next_s.wait_cnt = s.wait_cnt + 24'h1;
        next_s.tick = 4'h0;
        next_s.phase = 2'h0;
        if (rb_ready) begin // R08 R13 R23
          next_s.cnt = 12'h0;
          next_s.st = (s.op == op_read) ? st_rdata : st_status;
        end else if (s.wait_cnt == 24'(TIMEOUT_CYC)) begin
          next_s.error = 1'b1;
          next_s.st = st_done;
        end
      end
      st_rdata: begin
        // Stall between bytes while the buffer is full
        if (s.phase == 2'h0 && s.tick == 4'h0 && !rd_up.ready && s.re_n) begin
          next_s.tick = 4'h0;
        end else begin
          next_s.re_n = (s.phase == 2'h0) ? 1'b0 : 1'b1; // R04 R14
        end
        // Sync stages need the full low phase before the byte is trusted
        if (s.phase == 2'h1 && s.tick == 4'h0) begin
          next_s.rdata = s.din_s2; // R04
          next_s.rd_vld = 1'b1;
        end
        if (phase_end && s.phase == 2'h1) begin
          next_s.phase = 2'h0;
          next_s.cnt = s.cnt + 12'h1;
          if (s.cnt + 12'h1 == s.len || s.col + s.cnt + 12'h1 == `PAGE_BYTES) begin
            next_s.st = st_done;
          end
        end
      end
      st_status: begin
        // Status command, then one read strobe for the result
        if (s.phase < 2'h2) begin
          next_s.cle = 1'b1;
          next_s.oe_n = 1'b0;
          next_s.dout = `CMD_STATUS;
          next_s.we_n = (s.phase == 2'h0) ? 1'b0 : 1'b1;
        end else begin
          next_s.cle = 1'b0;
          next_s.oe_n = 1'b1;
          next_s.re_n = (s.phase == 2'h2) ? 1'b0 : 1'b1;
          if (s.phase == 2'h3 && s.tick == 4'h0) begin
            next_s.status = s.din_s2;
          end
          if (phase_end && s.phase == 2'h3) begin
            next_s.error = s.status[0]; // R07
            next_s.st = st_done;
          end
        end
      end
      default: begin
        next_s.ce_n = 1'b1;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.st = st_idle;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s <= '0;
      s.st <= st_idle;
      s.ce_n <= 1'b1;
      s.we_n <= 1'b1;
      s.re_n <= 1'b1;
      s.oe_n <= 1'b1;
      s.rb_sync <= 2'h0;
    end else begin
      s <= next_s;
    end
  end

  assign o_busy = s.busy;
  assign o_done = s.done;
  assign o_error = s.error;
  assign o_status = s.status;
  assign o_wr_ready = s.wr_ready;
  assign o_rd_valid = rd_down.valid;
  assign o_rd_data = rd_down.data;
  assign o_ce_n = s.ce_n;
  assign o_cle = s.cle;
  assign o_ale = s.ale;
  assign o_we_n = s.we_n;
  assign o_rd_strobe_n = s.re_n;
  assign o_wp_n = s.busy; // R07
  assign o_mux_bus_lines = s.dout;
  assign o_mux_bus_oe = s.oe_n;
endmodule

/* File: hw/skid_buffer.sv */
// Two-entry buffer between producer and consumer of a byte stream.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ns
module skid_buffer (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  byte_stream_if.dst up,
  byte_stream_if.src down
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
  } skid_state_t;

  skid_state_t s;
  skid_state_t next_s;
  logic push;
  logic pop;

  // Two entries so a stall in the drain never drops a byte in flight
  always_comb begin
    push = up.valid && (s.count != 2'h2);
    pop = (s.count != 2'h0) && down.ready;
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = up.data;
      next_s.wr_ptr = ~s.wr_ptr;
    end
    if (pop) begin
      next_s.rd_ptr = ~s.rd_ptr;
    end
    if (push && !pop) begin
      next_s.count = s.count + 2'h1;
    end else if (pop && !push) begin
      next_s.count = s.count - 2'h1;
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign up.ready = (s.count != 2'h2);
  assign down.valid = (s.count != 2'h0);
  assign down.data = s.mem[s.rd_ptr];
endmodule

/* File: shared/byte_stream_if.sv */
// Valid/ready byte stream between the controller and its skid buffer.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

/* File: shared/nand_host_params.svh */
// Constants for the NAND host controller: commands, geometry, timing counts.
// Assumes a 100 MHz system clock; included by the package, nand_host and the flash model.
//
// Function
// [R01] Command bytes go out with command-latch high, latched on write-strobe rise.
// [R02] Address bytes go out with address-latch high, only during address bytes.
// [R03] Data-in bytes go out with both latches low, one per write strobe.
// [R04] Device drives data while read strobe low; each fall advances column.
// [R05] Device floats the bus when deselected; host drives only on writes. The flash model drives the inverse of its last byte instead of floating.
// [R06] Device finishes program or erase even if chip select rises.
// [R07] Write-protect low blocks program and erase inside the device.
// [R08] Ready/busy is low during program, erase and array read.
// [R09] Ready/busy is open-drain and reports even when deselected.
// [R10] Page program writes one 2112-byte page, typically 250 us busy.
// [R11] Array holds 512 blocks of 64 pages each.
// [R12] Erase acts on whole blocks, typically 2 ms busy.
// [R13] Array-to-buffer load takes at most 25 us; wait ready before reading.
// [R14] Read-strobe cycles spaced no closer than 25 ns.
// [R15] Copy-back programs a buffered page to another page without reload.
// [R16] Cache program accepts new data while previous data programs.
// [R17] Host must correct at least four bit errors per 512 bytes; nand_host does no error correction.
// [R18] Device may auto-load page 0 after power-up for booting.
// [R19] Address is four bytes: two column then two row; extras ignored.
// [R20] Read, program and erase use setup command first, execute last.
// [R21] While busy the device accepts only reset and read-status.
// [R22] Columns 2048 to 2111 form the 64-byte spare area.
// [R23] Host waits for ready before any command but reset or status.
// [R24] Host holds chip select low through each whole sequence.
`ifndef NAND_HOST_PARAMS_SVH
`define NAND_HOST_PARAMS_SVH

`define CLK_MHZ 100
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_PROG1 8'h80
`define CMD_PROG2 8'h10
`define CMD_ERASE1 8'h60
`define CMD_ERASE2 8'hd0
`define CMD_RESET 8'hff
`define CMD_STATUS 8'h70
`define PAGE_BYTES 12'd2112
`define SPARE_START 12'd2048
`define ADDR_BYTES 3'd4
// Strobe phase: 3 cycles low, 3 high, 60 ns cycle covers 25 ns minimum
`define STROBE_NS 30
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
// Busy-sample delay before ready is trusted
`define WB_NS 100
`define WB_CYC ((`WB_NS * `CLK_MHZ + 999) / 1000)
`define TIMEOUT_US 10000
`define TIMEOUT_CYC (`TIMEOUT_US * `CLK_MHZ)

`endif

/* File: shared/nand_host_pkg.sv */
// Types for the NAND host controller.
// Assumes the params header sits on the include path.
`include "nand_host_params.svh"
package nand_host_pkg;
  typedef enum logic [1:0] {
    op_read = 2'h0,
    op_program = 2'h1,
    op_erase = 2'h2,
    op_reset = 2'h3
  } op_t;

  typedef enum logic [9:0] {
    st_idle = 10'h001,
    st_cmd1 = 10'h002,
    st_addr = 10'h004,
    st_wdata = 10'h008,
    st_cmd2 = 10'h010,
    st_wait_busy = 10'h020,
    st_wait_ready = 10'h040,
    st_rdata = 10'h080,
    st_status = 10'h100,
    st_done = 10'h200
  } state_t;
endpackage
